// *** testbench/pcm_color_matrix_asserts.sv ***
// port checks for the colour matrix
`timescale 1ns/1ps

module pcm_color_matrix_asserts
	import pcm_pkg::*;
(
	input wire logic            CLK,
	input wire logic            RST,
	input wire logic            DIRECTION_SELECT,
	input wire logic            PLACEMENT_SELECT,
	input wire logic            MODE_WRITE,
	input wire logic            VBLANK_START,
	input wire logic            PIX_IN_VALID,
	input wire logic            PIX_IN_READY,
	input wire logic            PIX_OUT_VALID,
	input wire logic            PIX_OUT_READY,
	input wire logic [CH_W-1:0] PIX_OUT_HIGH,
	input wire logic [CH_W-1:0] PIX_OUT_MEDIUM,
	input wire logic [CH_W-1:0] PIX_OUT_LOW,
	input wire logic            UPDATE_ARMED,
	input wire logic            ACTIVE_DIRECTION,
	input wire logic            ACTIVE_PLACEMENT
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);

	////////////////////////////////
	// load edge of the staged settings
	sequence s_load;
		UPDATE_ARMED && VBLANK_START;
	endsequence
	// pixel taken into the buffer
	sequence s_push;
		PIX_IN_VALID && PIX_IN_READY;
	endsequence

	AST_ARM: assert property (MODE_WRITE |=> UPDATE_ARMED)
		else $error("mode write did not arm");
	AST_DISARM: assert property (s_load ##0 !MODE_WRITE |=> !UPDATE_ARMED)
		else $error("load did not disarm");
	AST_IDLE: assert property (!UPDATE_ARMED && !MODE_WRITE |=> !UPDATE_ARMED)
		else $error("armed without a mode write");
	AST_DIR: assert property (s_load |=> ACTIVE_DIRECTION == $past(DIRECTION_SELECT))
		else $error("direction not loaded");
	AST_PLACE: assert property (s_load |=> ACTIVE_PLACEMENT == $past(PLACEMENT_SELECT))
		else $error("placement not loaded");
	AST_HOLD: assert property (!UPDATE_ARMED || !VBLANK_START |=> $stable(ACTIVE_DIRECTION))
		else $error("direction changed outside a load");
	AST_OUT_HOLD: assert property (PIX_OUT_VALID && !PIX_OUT_READY |=> PIX_OUT_VALID
		&& $stable({PIX_OUT_HIGH, PIX_OUT_MEDIUM, PIX_OUT_LOW}))
		else $error("stalled pixel not held");
	AST_LATENCY: assert property (s_push |-> ##[1:12] PIX_OUT_VALID)
		else $error("pixel never reached the output");
	AST_FULL: assert property (!PIX_IN_READY && PIX_OUT_VALID && !PIX_OUT_READY
		|=> !PIX_IN_READY)
		else $error("full buffer took a pixel while stalled");
endmodule

bind pcm_color_matrix pcm_color_matrix_asserts u_pcm_color_matrix_asserts (
	.CLK(CLK), .RST(RST), .DIRECTION_SELECT(DIRECTION_SELECT),
	.PLACEMENT_SELECT(PLACEMENT_SELECT), .MODE_WRITE(MODE_WRITE),
	.VBLANK_START(VBLANK_START), .PIX_IN_VALID(PIX_IN_VALID), .PIX_IN_READY(PIX_IN_READY),
	.PIX_OUT_VALID(PIX_OUT_VALID), .PIX_OUT_READY(PIX_OUT_READY),
	.PIX_OUT_HIGH(PIX_OUT_HIGH), .PIX_OUT_MEDIUM(PIX_OUT_MEDIUM), .PIX_OUT_LOW(PIX_OUT_LOW),
	.UPDATE_ARMED(UPDATE_ARMED), .ACTIVE_DIRECTION(ACTIVE_DIRECTION),
	.ACTIVE_PLACEMENT(ACTIVE_PLACEMENT)
);

// *** testbench/pcm_color_matrix_tb.sv ***
// self-checking bench for the colour matrix
`timescale 1ns/1ps

module pcm_color_matrix_tb
	import pcm_pkg::*;
;
	logic              clk, rst, mode_wr, vblank, dir_sel, place_sel, stall, slow;
	logic              in_valid, in_ready, out_valid, out_ready, armed, act_dir, act_place;
	logic [WORD_W-1:0] cw [6], aw [6];   // staged and expected active words
	logic [OFS_W-1:0]  ofs [3], aofs [3]; // staged and expected active offsets
	logic              adir;             // expected active direction
	logic [CH_W-1:0]   ph, pm, pl, oh, om, ol;
	logic [PIX_W-1:0]  exq[$];           // expected pixels in order
	int                err_count, samples_checked;

	pcm_color_matrix u_pcm_color_matrix (
		.CLK(clk), .RST(rst), .COEF_WORD0(cw[0]), .COEF_WORD1(cw[1]), .COEF_WORD2(cw[2]),
		.COEF_WORD3(cw[3]), .COEF_WORD4(cw[4]), .COEF_WORD5(cw[5]), .OFFSET_HIGH(ofs[0]),
		.OFFSET_MEDIUM(ofs[1]), .OFFSET_LOW(ofs[2]), .DIRECTION_SELECT(dir_sel),
		.PLACEMENT_SELECT(place_sel), .MODE_WRITE(mode_wr), .VBLANK_START(vblank),
		.PIX_IN_VALID(in_valid), .PIX_IN_READY(in_ready), .PIX_IN_HIGH(ph),
		.PIX_IN_MEDIUM(pm), .PIX_IN_LOW(pl), .PIX_OUT_VALID(out_valid),
		.PIX_OUT_READY(out_ready), .PIX_OUT_HIGH(oh), .PIX_OUT_MEDIUM(om), .PIX_OUT_LOW(ol),
		.UPDATE_ARMED(armed), .ACTIVE_DIRECTION(act_dir), .ACTIVE_PLACEMENT(act_place)
	);
	pcm_pixel_sink u_pcm_pixel_sink (
		.clk(clk), .rst(rst), .valid(out_valid), .ready(out_ready), .hi(oh), .md(om),
		.lo(ol), .stall(stall), .slow(slow)
	);

	////////////////////////////////
	// compare and count
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// decoded coefficient, 12 fraction bits
	function automatic int cfix(logic [15:0] c);
		int v;
		case (c[14:12])
			3'h6: v = c[11:3] * 32;
			3'h7: v = c[11:3] * 16;
			3'h0: v = c[11:3] * 8;
			3'h1: v = c[11:3] * 4;
			3'h2: v = c[11:3] * 2;
			3'h3: v = c[11:3];
			default: v = 0;
		endcase
		return c[15] ? -v : v;
	endfunction

	// one output row, floored and clamped
	function automatic logic [CH_W-1:0] row(logic [15:0] a, b, c, int xh, xm, xl);
		int s;
		s = (cfix(a) * xh + cfix(b) * xm + cfix(c) * xl) >>> 12;
		if (s < 0)
			return 10'h000;
		if (s > 1023)
			return CH_MAX;
		return s[9:0];
	endfunction

	// expected output pixel under the active settings
	function automatic logic [PIX_W-1:0] model(logic [CH_W-1:0] h, m, l);
		int xh, xm, xl;
		logic [CH_W-1:0] y, u, v;
		xh = int'(h) + int'($signed(aofs[0]));
		xm = int'(m) + int'($signed(aofs[1]));
		xl = int'(l) + int'($signed(aofs[2]));
		y = row(aw[0][31:16], aw[0][15:0], aw[1][31:16], xh, xm, xl);
		u = row(aw[2][31:16], aw[2][15:0], aw[3][31:16], xh, xm, xl);
		v = row(aw[4][31:16], aw[4][15:0], aw[5][31:16], xh, xm, xl);
		return adir ? {y, u, v} : {u, y, v};
	endfunction

	// arm, wait, then load at vblank
	task automatic load();
		mode_wr = 1;
		@(negedge clk);
		mode_wr = 0;
		chk("armed", armed, 1);
		repeat (2) @(negedge clk);
		vblank = 1;
		@(negedge clk);
		vblank = 0;
		chk("disarmed", armed, 0);
		chk("direction", act_dir, dir_sel);
		chk("placement", act_place, place_sel);
		aw = cw;
		aofs = ofs;
		adir = dir_sel;
	endtask

	// offer one pixel until taken
	task automatic send(input logic [CH_W-1:0] h, m, l);
		int n;
		in_valid = 1;
		ph = h;
		pm = m;
		pl = l;
		exq.push_back(model(h, m, l));
		for (n = 0; n < 100 && !in_ready; n++)
			@(negedge clk);
		@(negedge clk);
	endtask

	// wait for all expected pixels and compare in order
	task automatic drain();
		int n;
		in_valid = 0;
		for (n = 0; n < 300 && u_pcm_pixel_sink.got.size() < exq.size(); n++)
			@(negedge clk);
		chk("count", u_pcm_pixel_sink.got.size(), exq.size());
		while (exq.size() > 0 && u_pcm_pixel_sink.got.size() > 0)
			chk("pixel", u_pcm_pixel_sink.got.pop_front(), exq.pop_front());
		exq.delete();
	endtask

	////////////////////////////////
	// scenarios
	task automatic t_reset();
		chk("in ready", in_ready, 1);
		chk("armed", armed, 0);
		chk("act dir", act_dir, 0);
		send(10'h3FF, 10'h200, 10'h001);
		drain();
	endtask

	// staged values ignored without a mode write
	task automatic t_refuse();
		cw = '{default: 32'h7800_7800};
		dir_sel = 1;
		vblank = 1;
		@(negedge clk);
		vblank = 0;
		chk("no arm", armed, 0);
		chk("dir kept", act_dir, 0);
		send(10'h155, 10'h155, 10'h155);
		drain();
	endtask

	// standard forward table, slow sink
	task automatic t_forward();
		cw = '{32'h0800_9D68, 32'hBA68_0000, 32'h1990_0968, 32'h3E98_0000,
			32'hAAC8_9A98, 32'h0800_0000};
		dir_sel = DIR_RGB_TO_YUV;
		place_sel = PLACE_BEFORE;
		load();
		slow = 1;
		send(10'h000, 10'h000, 10'h000);
		send(10'h3FF, 10'h3FF, 10'h3FF);
		send(10'h3FF, 10'h000, 10'h000);
		send(10'h000, 10'h000, 10'h3FF);
		drain();
		slow = 0;
	endtask

	// every exponent code, sign and packing
	task automatic t_exponent();
		for (int i = 0; i < 8; i++) begin
			cw = '{default: 32'h0000_0000};
			cw[0] = {1'b0, i[2:0], 9'h1A5, 3'h7, 16'h0000};
			cw[1] = 32'h0000_FFFF;
			cw[2] = {1'b1, 3'h0, 9'h100, 3'h0, 16'h0000};
			cw[4] = 32'h0800_7800;
			dir_sel = DIR_YUV_TO_RGB;
			load();
			send(10'h0C3, 10'h3FF, 10'h3FF);
			drain();
		end
	endtask

	// standard reverse table with offsets
	task automatic t_reverse();
		cw = '{32'h7AF8_7800, 32'h0000_0000, 32'h8B28_7800, 32'h9AC0_0000,
			32'h0000_7800, 32'h7DD8_0000};
		ofs = '{13'h1F80, 13'h1FF0, 13'h1F80};
		place_sel = PLACE_AFTER;
		load();
		send(10'h0F0, 10'h0EB, 10'h080);
		send(10'h010, 10'h3FF, 10'h3F0);
		drain();
	endtask

	// fill the buffer against a stalled sink, then drain
	task automatic t_fifo();
		int n;
		stall = 1;
		for (n = 0; n < 16 && in_ready; n++) begin
			in_valid = 1;
			ph = n[9:0];
			pm = 10'h3FF - n[9:0];
			pl = 10'h0AA;
			exq.push_back(model(ph, pm, pl));
			@(negedge clk);
		end
		in_valid = 0;
		chk("accepted", n, FIFO_DEPTH + 1);
		repeat (4) @(negedge clk);
		chk("full holds", in_ready, 0);
		stall = 0;
		drain();
	endtask

	// mode write in the vblank cycle: arms when idle, reloads when armed
	task automatic t_rearm();
		mode_wr = 1;
		vblank = 1;
		dir_sel = DIR_RGB_TO_YUV;
		@(negedge clk);
		mode_wr = 0;
		vblank = 0;
		chk("armed only", armed, 1);
		chk("not loaded", act_dir, DIR_YUV_TO_RGB);
		mode_wr = 1;
		vblank = 1;
		@(negedge clk);
		mode_wr = 0;
		vblank = 0;
		chk("rearmed", armed, 1);
		chk("loaded", act_dir, DIR_RGB_TO_YUV);
		dir_sel = DIR_YUV_TO_RGB;
		vblank = 1;
		@(negedge clk);
		vblank = 0;
		chk("reloaded", act_dir, DIR_YUV_TO_RGB);
		chk("disarmed", armed, 0);
		adir = dir_sel;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////
	// clock
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end

	// watchdog
	initial begin
		#200000;
		err_count++;
		wrap_up();
	end

	// main sequence
	initial begin
		{rst, mode_wr, vblank, dir_sel, place_sel, stall, slow, in_valid} = 8'h80;
		{ph, pm, pl} = '0;
		cw = '{default: 32'h0000_0000};
		ofs = '{default: 13'h0000};
		aw = cw;
		aofs = ofs;
		adir = 0;
		err_count = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 0;
		t_reset();
		t_refuse();
		t_forward();
		t_exponent();
		t_reverse();
		t_rearm();
		t_fifo();
		wrap_up();
	end
endmodule

// *** testbench/pcm_pixel_sink.sv ***
// downstream pixel sink that records accepted pixels
`timescale 1ns/1ps

module pcm_pixel_sink
	import pcm_pkg::*;
(
	input  wire logic            clk,
	input  wire logic            rst,
	input  wire logic            valid,
	output logic                 ready,
	input  wire logic [CH_W-1:0] hi,
	input  wire logic [CH_W-1:0] md,
	input  wire logic [CH_W-1:0] lo,
	input  wire logic            stall,
	input  wire logic            slow
);
	logic             tick_r;  // alternates for slow mode
	logic [PIX_W-1:0] got[$];  // accepted pixels, oldest first

	// withheld while stalled, every other cycle when slow
	assign ready = !stall && (!slow || tick_r);

	// record each pixel at its handshake edge
	always @(posedge clk) begin
		tick_r <= rst ? 1'b0 : !tick_r;
		if (!rst && valid && ready)
			got.push_back({hi, md, lo});
	end
endmodule

// *** verilog/pcm_color_matrix.sv ***
// per-pipe 3x3 colour space matrix with double-buffered settings
// How it works
// RULE1: each pipe owns twelve values, six words
// RULE2: converts RGB to YUV or YUV to RGB
// RULE3: high channel is msbs; RGB is R,G,B
// RULE4: YUV output carries U, Y, V
// RULE5: settings load at vblank after mode write
// RULE6: coefficient is sign, exponent, mantissa, reserved
// RULE7: two coefficients packed per 32-bit word
// RULE8: exponent scales mantissa four down to eighth
// RULE9: each output is three products summed
// RULE10: software loads standard forward encodings
// RULE11: reverse input carries V, Y, U
// RULE12: software sets reverse offsets -128, -16, -128
// RULE13: unity encodes 0x7800, zero 0x0000
// RULE14: direction bit picks forward or reverse
// RULE15: 13-bit signed offset added on entry
// RULE16: placement bit puts matrix before or after; here it is only held and shown on ACTIVE_PLACEMENT
// RULE17: outputs saturate, never wrap
`timescale 1ns/1ps

module pcm_color_matrix
	import pcm_pkg::*;
(
	input  wire logic              CLK,
	input  wire logic              RST,
	input  wire logic [WORD_W-1:0] COEF_WORD0,
	input  wire logic [WORD_W-1:0] COEF_WORD1,
	input  wire logic [WORD_W-1:0] COEF_WORD2,
	input  wire logic [WORD_W-1:0] COEF_WORD3,
	input  wire logic [WORD_W-1:0] COEF_WORD4,
	input  wire logic [WORD_W-1:0] COEF_WORD5,
	input  wire logic [OFS_W-1:0]  OFFSET_HIGH,
	input  wire logic [OFS_W-1:0]  OFFSET_MEDIUM,
	input  wire logic [OFS_W-1:0]  OFFSET_LOW,
	input  wire logic              DIRECTION_SELECT,
	input  wire logic              PLACEMENT_SELECT,
	input  wire logic              MODE_WRITE,
	input  wire logic              VBLANK_START,
	input  wire logic              PIX_IN_VALID,
	output logic                   PIX_IN_READY,
	input  wire logic [CH_W-1:0]   PIX_IN_HIGH,
	input  wire logic [CH_W-1:0]   PIX_IN_MEDIUM,
	input  wire logic [CH_W-1:0]   PIX_IN_LOW,
	output logic                   PIX_OUT_VALID,
	input  wire logic              PIX_OUT_READY,
	output logic [CH_W-1:0]        PIX_OUT_HIGH,
	output logic [CH_W-1:0]        PIX_OUT_MEDIUM,
	output logic [CH_W-1:0]        PIX_OUT_LOW,
	output logic                   UPDATE_ARMED,
	output logic                   ACTIVE_DIRECTION,
	output logic                   ACTIVE_PLACEMENT
);

	////////////////////////////////////////////////////////////////////////////
	// arithmetic helpers

	// packed coefficient to signed fixed point with FRAC_W fraction bits
	function automatic logic signed [FIX_W-1:0] coef_decode(
		input logic [COEF_W-1:0] w
	);
		logic [MANT_W-1:0]       mant;
		logic [FIX_W-1:0]        mag;
		mant = w[MANT_HI:MANT_LO];                          // RULE6
		case (w[EXP_HI:EXP_LO])                             // RULE8
			EXP_X4:      mag = {2'h0, mant, 5'h00};
			EXP_X2:      mag = {3'h0, mant, 4'h0};
			EXP_X1:      mag = {4'h0, mant, 3'h0};
			EXP_HALF:    mag = {5'h00, mant, 2'h0};
			EXP_QUARTER: mag = {6'h00, mant, 1'h0};
			EXP_EIGHTH:  mag = {7'h00, mant};
			default:     mag = '0;                          // reserved scale
		endcase
		if (w[SIGN_B]) begin                                // RULE6
			return -$signed(mag);
		end
		return $signed(mag);
	endfunction

	// channel plus its signed entry offset
	function automatic logic signed [IN_W-1:0] add_offset(
		input logic [CH_W-1:0]  ch,
		input logic [OFS_W-1:0] ofs
	);
		return $signed(IN_W'(ch)) + $signed({ofs[OFS_W-1], ofs});   // RULE15
	endfunction

	// one row of the matrix: three products summed
	function automatic logic signed [SUM_W-1:0] mac_row(
		input logic signed [FIX_W-1:0] ch, cm, cl,
		input logic signed [IN_W-1:0]  xh, xm, xl
	);
		logic signed [PROD_W-1:0] ph, pm, pl;
		ph = xh * ch;
		pm = xm * cm;
		pl = xl * cl;
		return SUM_W'(ph) + SUM_W'(pm) + SUM_W'(pl);        // RULE9
	endfunction

	// drop fraction, clamp into the channel range
	function automatic logic [CH_W-1:0] saturate(
		input logic signed [SUM_W-1:0] s
	);
		logic signed [SUM_W-1:0] whole;
		whole = s >>> FRAC_W;
		if (whole < 0) begin                                // RULE17
			return '0;
		end else if (whole > $signed(SUM_W'(CH_MAX))) begin // RULE17
			return CH_MAX;
		end
		return whole[CH_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// declarations
	pcm_arm_t          arm_r, arm_nxt;            // arming state
	logic              load;                      // copy staged to active
	logic [COEF_W-1:0] coef_r [NUM_COEF];         // active coefficients
	logic [COEF_W-1:0] coef_nxt [NUM_COEF];
	logic [COEF_W-1:0] staged [NUM_COEF];         // software values, unpacked
	logic [OFS_W-1:0]  ofs_h_r, ofs_m_r, ofs_l_r; // active offsets
	logic [OFS_W-1:0]  ofs_h_nxt, ofs_m_nxt, ofs_l_nxt;
	logic              dir_r, dir_nxt;            // active direction
	logic              place_r, place_nxt;        // active placement

	logic              fifo_valid;                // head pixel present
	logic              fifo_pop;                  // head consumed
	logic [PIX_W-1:0]  fifo_data;                 // head pixel
	logic signed [IN_W-1:0]  in_h, in_m, in_l;    // offset channels
	logic signed [FIX_W-1:0] k [NUM_COEF];        // decoded coefficients
	logic [CH_W-1:0]   row_y, row_u, row_v;       // saturated row results
	logic              out_valid_r, out_valid_nxt;
	logic [CH_W-1:0]   out_h_r, out_m_r, out_l_r;
	logic [CH_W-1:0]   out_h_nxt, out_m_nxt, out_l_nxt;

	////////////////////////////////////////////////////////////////////////////
	// unpack the six coefficient words: both halves of words 0, 2, 4, upper half of 1, 3, 5
	always_comb begin
		staged[C_RY] = COEF_WORD0[WORD_W-1:HALF_LO];        // RULE7
		staged[C_GY] = COEF_WORD0[COEF_W-1:0];              // RULE7
		staged[C_BY] = COEF_WORD1[WORD_W-1:HALF_LO];        // RULE1
		staged[C_RU] = COEF_WORD2[WORD_W-1:HALF_LO];
		staged[C_GU] = COEF_WORD2[COEF_W-1:0];
		staged[C_BU] = COEF_WORD3[WORD_W-1:HALF_LO];
		staged[C_RV] = COEF_WORD4[WORD_W-1:HALF_LO];
		staged[C_GV] = COEF_WORD4[COEF_W-1:0];
		staged[C_BV] = COEF_WORD5[WORD_W-1:HALF_LO];        // low halves unused
	end

	////////////////////////////////////////////////////////////////////////////
	// arming: a mode write arms, next vblank start loads
	always_comb begin
		load    = (arm_r == ARM_PENDING) && VBLANK_START;   // RULE5
		arm_nxt = arm_r;
		unique case (arm_r)
			ARM_IDLE: begin
				if (MODE_WRITE) begin
					arm_nxt = ARM_PENDING;
				end
			end
			ARM_PENDING: begin
				// a new write in the load cycle keeps it armed
				if (VBLANK_START && !MODE_WRITE) begin
					arm_nxt = ARM_IDLE;
				end
			end
		endcase
	end

	// active set follows the staged set only on load
	always_comb begin
		for (int i = 0; i < NUM_COEF; i++) begin
			coef_nxt[i] = load ? staged[i] : coef_r[i];     // RULE5
		end
		ofs_h_nxt = load ? OFFSET_HIGH : ofs_h_r;
		ofs_m_nxt = load ? OFFSET_MEDIUM : ofs_m_r;
		ofs_l_nxt = load ? OFFSET_LOW : ofs_l_r;
		dir_nxt   = load ? DIRECTION_SELECT : dir_r;
		place_nxt = load ? PLACEMENT_SELECT : place_r;      // RULE16
	end

	// settings registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			arm_r   <= ARM_IDLE;
			ofs_h_r <= OFS_RST;
			ofs_m_r <= OFS_RST;
			ofs_l_r <= OFS_RST;
			dir_r   <= DIR_RGB_TO_YUV;
			place_r <= PLACE_AFTER;
			for (int i = 0; i < NUM_COEF; i++) begin
				coef_r[i] <= COEF_RST;
			end
		end else begin
			arm_r   <= arm_nxt;
			ofs_h_r <= ofs_h_nxt;
			ofs_m_r <= ofs_m_nxt;
			ofs_l_r <= ofs_l_nxt;
			dir_r   <= dir_nxt;
			place_r <= place_nxt;
			for (int i = 0; i < NUM_COEF; i++) begin
				coef_r[i] <= coef_nxt[i];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input buffer
	pcm_fifo #(
		.WIDTH (PIX_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (PIX_IN_VALID),
		.in_ready  (PIX_IN_READY),
		.in_data   ({PIX_IN_HIGH, PIX_IN_MEDIUM, PIX_IN_LOW}),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// output stage stalls the buffer when downstream holds off
	assign fifo_pop = fifo_valid && (!out_valid_r || PIX_OUT_READY);

	////////////////////////////////////////////////////////////////////////////
	// matrix arithmetic on the head pixel
	always_comb begin
		// first coefficient column meets the high channel
		in_h = add_offset(fifo_data[PIX_W-1:2*CH_W], ofs_h_r);     // RULE3
		in_m = add_offset(fifo_data[2*CH_W-1:CH_W], ofs_m_r);
		in_l = add_offset(fifo_data[CH_W-1:0], ofs_l_r);
		for (int i = 0; i < NUM_COEF; i++) begin
			k[i] = coef_decode(coef_r[i]);
		end
		row_y = saturate(mac_row(k[C_RY], k[C_GY], k[C_BY], in_h, in_m, in_l));
		row_u = saturate(mac_row(k[C_RU], k[C_GU], k[C_BU], in_h, in_m, in_l));
		row_v = saturate(mac_row(k[C_RV], k[C_GV], k[C_BV], in_h, in_m, in_l));
	end

	// route rows to channels by direction, then register
	always_comb begin
		out_valid_nxt = out_valid_r;
		out_h_nxt     = out_h_r;
		out_m_nxt     = out_m_r;
		out_l_nxt     = out_l_r;
		if (fifo_pop) begin
			out_valid_nxt = 1'b1;
			if (dir_r == DIR_YUV_TO_RGB) begin              // RULE14
				// red, green, blue on high, medium, low
				out_h_nxt = row_y;                          // RULE2
				out_m_nxt = row_u;
				out_l_nxt = row_v;
			end else begin
				// U high, Y medium, V low
				out_h_nxt = row_u;                          // RULE4
				out_m_nxt = row_y;                          // RULE4
				out_l_nxt = row_v;                          // RULE2
			end
		end else if (PIX_OUT_READY) begin
			out_valid_nxt = 1'b0;                           // taken, none new
		end
	end

	// output registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			out_valid_r <= 1'b0;
			out_h_r     <= CH_RST;
			out_m_r     <= CH_RST;
			out_l_r     <= CH_RST;
		end else begin
			out_valid_r <= out_valid_nxt;
			out_h_r     <= out_h_nxt;
			out_m_r     <= out_m_nxt;
			out_l_r     <= out_l_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign PIX_OUT_VALID    = out_valid_r;
	assign PIX_OUT_HIGH     = out_h_r;
	assign PIX_OUT_MEDIUM   = out_m_r;
	assign PIX_OUT_LOW      = out_l_r;
	assign UPDATE_ARMED     = (arm_r == ARM_PENDING);
	assign ACTIVE_DIRECTION = dir_r;
	assign ACTIVE_PLACEMENT = place_r;

endmodule

// *** verilog/pcm_fifo.sv ***
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps

module pcm_fifo
	import pcm_pkg::*;
#(
	parameter int WIDTH = PIX_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];            // storage words
	logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;     // next slot to fill
	logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;     // oldest word
	logic [AW:0]      count_r, count_nxt;       // words held
	logic             push, pop;

	////////////////////////////////////////////////////////////////////////////
	// handshakes: full refuses, empty shows no valid
	assign in_ready  = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data  = mem_r[rd_ptr_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointer wrap helper
	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		if (p == AW'(DEPTH - 1)) begin
			return '0;
		end
		return p + AW'(1);
	endfunction

	// next pointers and fill count
	always_comb begin
		wr_ptr_nxt = push ? bump(wr_ptr_r) : wr_ptr_r;
		rd_ptr_nxt = pop ? bump(rd_ptr_r) : rd_ptr_r;
		count_nxt  = count_r;
		if (push && !pop) begin
			count_nxt = count_r + (AW+1)'(1);
		end else if (pop && !push) begin
			count_nxt = count_r - (AW+1)'(1);
		end
	end

	// pointer registers
	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			wr_ptr_r <= wr_ptr_nxt;
			rd_ptr_r <= rd_ptr_nxt;
			count_r  <= count_nxt;
		end
	end

	// storage is written only on an accepted word
	always_ff @(posedge clk) begin
		if (push) begin
			mem_r[wr_ptr_r] <= in_data;
		end
	end

endmodule

// *** verilog/pcm_pkg.sv ***
// constants and types shared by the colour matrix and its input buffer
package pcm_pkg;

	////////////////////////////////////////////////////////////////////////////
	// pixel and offset widths
	localparam int CH_W       = 10;             // bits per colour channel
	localparam int OFS_W      = 13;             // input offset, two's complement
	localparam int IN_W       = OFS_W + 1;      // channel after offset, signed
	localparam int PIX_W      = 3 * CH_W;       // high, medium, low packed
	localparam int WORD_W     = 32;             // one coefficient register
	localparam int NUM_WORDS  = 6;              // coefficient registers per pipe
	localparam int NUM_COEF   = 9;              // coefficients in the matrix
	localparam int FIFO_DEPTH = 8;              // pixels buffered at the input

	////////////////////////////////////////////////////////////////////////////
	// coefficient field layout
	localparam int COEF_W  = 16;                // one packed coefficient
	localparam int HALF_LO = 16;                // lsb of the upper half word
	localparam int SIGN_B  = 15;                // sign bit
	localparam int EXP_HI  = 14;                // exponent field
	localparam int EXP_LO  = 12;
	localparam int MANT_HI = 11;                // mantissa field
	localparam int MANT_LO = 3;
	localparam int MANT_W  = MANT_HI - MANT_LO + 1;

	// exponent codes and the scale each gives
	localparam logic [2:0] EXP_X4      = 3'h6;  // times four
	localparam logic [2:0] EXP_X2      = 3'h7;  // times two
	localparam logic [2:0] EXP_X1      = 3'h0;  // times one
	localparam logic [2:0] EXP_HALF    = 3'h1;  // one half
	localparam logic [2:0] EXP_QUARTER = 3'h2;  // one quarter
	localparam logic [2:0] EXP_EIGHTH  = 3'h3;  // one eighth

	////////////////////////////////////////////////////////////////////////////
	// fixed point arithmetic
	localparam int FIX_W  = 16;                 // decoded coefficient, signed
	localparam int FRAC_W = 12;                 // fraction bits of a coefficient
	localparam int PROD_W = IN_W + FIX_W;       // one product
	localparam int SUM_W  = PROD_W + 2;         // sum of three products
	localparam logic [CH_W-1:0] CH_MAX = 10'h3FF;   // top of channel range

	// coefficient slots in the active set
	localparam int C_RY = 0;
	localparam int C_GY = 1;
	localparam int C_BY = 2;
	localparam int C_RU = 3;
	localparam int C_GU = 4;
	localparam int C_BU = 5;
	localparam int C_RV = 6;
	localparam int C_GV = 7;
	localparam int C_BV = 8;

	////////////////////////////////////////////////////////////////////////////
	// mode settings and reset values
	localparam logic DIR_RGB_TO_YUV = 1'b0;     // direction select codes
	localparam logic DIR_YUV_TO_RGB = 1'b1;
	localparam logic PLACE_AFTER    = 1'b0;     // after gamma and enhancement
	localparam logic PLACE_BEFORE   = 1'b1;
	localparam logic [COEF_W-1:0] COEF_RST = 16'h0000;
	localparam logic [OFS_W-1:0]  OFS_RST  = 13'h0000;
	localparam logic [CH_W-1:0]   CH_RST   = 10'h000;

	// double buffer arming state
	typedef enum logic {ARM_IDLE, ARM_PENDING} pcm_arm_t;

endpackage
